/* rtl/csr_cfg.svh */
// Offsets, field positions and reset values of the core register bank
`ifndef CSR_CFG_SVH
`define CSR_CFG_SVH

`define CSR_OFF_INDIRECT   7'h00
`define CSR_OFF_TIMER0     7'h01
`define CSR_OFF_PCLOW      7'h02
`define CSR_OFF_STATUS     7'h03
`define CSR_OFF_POINTER    7'h04
`define CSR_OFF_PORT_A_DATA      7'h05
`define CSR_OFF_PORT_B_DATA      7'h06
`define CSR_OFF_PORT_C_DATA      7'h07
`define CSR_OFF_POWER      7'h08
`define CSR_OFF_WAKEUP     7'h09
`define CSR_OFF_PCBUF      7'h0a
`define CSR_SFR_LAST       7'h1f

`define CSR_ST_CARRY       0
`define CSR_ST_HALF        1
`define CSR_ST_ZERO        2
`define CSR_ST_PD_N        3
`define CSR_ST_TO_N        4
`define CSR_PW_LVR         3
`define CSR_PW_PA5PU       4
`define CSR_PW_LVD         5
`define CSR_PW_WDT         7

`define CSR_RST_STATUS     8'h18
`define CSR_RST_POWER      8'h98
`define CSR_RST_WAKEUP     8'hff
`define CSR_RST_PCLOW      8'h00
`define CSR_RST_ZERO8      8'h00

`endif

/* rtl/csr_pkg.sv */
// Types shared by the core register bank
package csr_pkg;
   typedef enum logic [1:0] {
      CSR_SRC_INST = 2'b00,
      CSR_SRC_EXT  = 2'b01,
      CSR_SRC_LOSC = 2'b11
   } csr_tsrc_t;

   typedef enum logic [2:0] {
      CSR_BR_NONE  = 3'b000,
      CSR_BR_SJMP  = 3'b001,
      CSR_BR_SCALL = 3'b011,
      CSR_BR_LJMP  = 3'b010,
      CSR_BR_LONG_CALL = 3'b110
   } csr_branch_t;

   // Register access from the instruction core
   typedef struct packed {
      logic       rd;
      logic       wr;
      logic [6:0] addr;
      logic [7:0] wdata;
   } csr_acc_t;

   // Arithmetic flag update from the ALU
   typedef struct packed {
      logic upd;
      logic carry;
      logic half;
      logic [7:0] result;
   } csr_alu_t;

   typedef struct packed {
      logic [7:0]  timer0;
      logic [10:0] pc;
      logic [7:0]  status;
      logic [7:0]  pointer;
      logic [7:0]  latchA;
      logic [7:0]  latchB;
      logic [1:0]  latchC;
      logic [7:0]  power;
      logic [7:0]  wakeup;
      logic [2:0]  pcHigh;
      logic        extPrev;
      logic        loscPrev;
      logic [10:0] stackPush;
      logic        pushValid;
   } csr_state_t;
endpackage

/* rtl/csr_core_special_register_bank.sv */
// Core special-function register bank: pointer, timer0, program counter, status, ports, power
`include "csr_cfg.svh"

// Function
// - Indirect port redirects to pointed register
// - Timer0 reads live, write replaces count
// - Timer0 clock from three selectable sources
// - Low byte of 11-bit counter, increments
// - Upper counter bits only via high buffer
// - Short jump: bits 10:9 from buffer 2:1
// - Short call: bits 10:8 from buffer, push
// - Long jump/call: all bits from instruction
// - Carry set on carry or no borrow
// - Half carry from fourth bit
// - Zero flag follows result equal zero
// - Power-down flag: set clear-wdt, cleared sleep
// - Time-out flag: set wdt/sleep, cleared timeout
// - Status 7:6 selects data bank
// - Pointer selects 128 registers; spare top bit stores
// - Port read: pin or latch per option
// - Port write loads output latch
// - Watchdog enable bit, resets to one
// - Low-voltage reset and detector enables
// - Active-low pin A5 pull-up control
// - Port B wake-up enables, reset ones
// - Special offsets mirror across all banks
module csr_core_special_register_bank (
   // Clock and reset
   input  wire logic                 core_clk,
   input  wire logic                 sys_rst,
   // Register access from the core, one instruction per cycle
   input  wire csr_pkg::csr_acc_t    acc,
   output logic      [7:0]           rdata,
   // General-purpose memory behind the pointer and bank bits
   output logic                      gprRd,
   output logic                      gprWr,
   output logic      [8:0]           gprAddr,
   output logic      [7:0]           gprWdata,
   input  wire logic [7:0]           gprRdata,
   // Instruction flow
   input  wire logic                 instDone,
   input  wire csr_pkg::csr_branch_t branch,
   input  wire logic [10:0]          branchTarget,
   output logic      [10:0]          pcOut,
   output logic                      stackPushValid,
   output logic      [10:0]          stackPushAddr,
   // Arithmetic results
   input  wire csr_pkg::csr_alu_t    alu,
   // Power events
   input  wire logic                 sleepExec,
   input  wire logic                 clrWdtExec,
   input  wire logic                 wdtTimeout,
   // Timer0 sources and configuration
   input  wire logic                 timer0ModeBit,
   input  wire logic                 cfgTimer0LowOsc,
   input  wire logic                 externalTimerClockPin,
   input  wire logic                 lowOscClk,
   // Port pins and direction
   input  wire logic [7:0]           pinA,
   input  wire logic [7:0]           pinB,
   input  wire logic [1:0]           pinC,
   input  wire logic [7:0]           dirOutA,
   input  wire logic [7:0]           dirOutB,
   input  wire logic [1:0]           dirOutC,
   input  wire logic                 portReadSourceOption,
   output logic      [7:0]           latchA,
   output logic      [7:0]           latchB,
   output logic      [1:0]           latchC,
   // Power control, wake-up enables and bank select
   output logic                      watchdogEnable,
   output logic                      lowVoltageResetEnable,
   output logic                      lowVoltageDetectEnable,
   output logic                      pa5PullupDisable,
   output logic      [7:0]           pinWakeupEnable,
   output logic      [1:0]           bankSelect
);

   csr_pkg::csr_state_t state_q;
   csr_pkg::csr_state_t state_d;
   csr_pkg::csr_tsrc_t  tsrc;
   logic                indirect;
   logic [6:0]          effAddr;
   logic                isSfr;
   logic                tick;
   logic [7:0]          rdMux;

   // Timer0 source: mode bit picks external, config picks low oscillator
   always_comb begin
      if (timer0ModeBit) begin
         tsrc = csr_pkg::CSR_SRC_EXT;
      end else if (cfgTimer0LowOsc) begin
         tsrc = csr_pkg::CSR_SRC_LOSC;
      end else begin
         tsrc = csr_pkg::CSR_SRC_INST;
      end
   end

   // Slow clocks are sampled as levels; a tick is one rising edge seen
   always_comb begin
      unique case (tsrc)
         csr_pkg::CSR_SRC_INST: tick = instDone;
         csr_pkg::CSR_SRC_EXT:  tick = externalTimerClockPin & ~state_q.extPrev;
         csr_pkg::CSR_SRC_LOSC: tick = lowOscClk & ~state_q.loscPrev;
      endcase
   end

   // Indirect access swaps in the pointer's low seven bits
   assign indirect = (acc.addr == `CSR_OFF_INDIRECT);
   assign effAddr  = indirect ? state_q.pointer[6:0] : acc.addr;
   // Low offsets are the same registers in every bank
   assign isSfr    = (effAddr <= `CSR_SFR_LAST);

   // Pointer at zero again points at itself; treated as reading zero
   assign gprRd    = acc.rd & ~isSfr;
   assign gprWr    = acc.wr & ~isSfr;
   assign gprAddr  = {state_q.status[7:6], effAddr};
   assign gprWdata = acc.wdata;

   // Read mux; ports pick pin or latch for output bits
   always_comb begin
      rdMux = `CSR_RST_ZERO8;
      unique case (effAddr)
         `CSR_OFF_TIMER0:  rdMux = state_q.timer0;
         `CSR_OFF_PCLOW:   rdMux = state_q.pc[7:0];
         `CSR_OFF_STATUS:  rdMux = state_q.status;
         `CSR_OFF_POINTER: rdMux = state_q.pointer;
         `CSR_OFF_PORT_A_DATA:   rdMux = portReadSourceOption
                                   ? ((dirOutA & state_q.latchA) | (~dirOutA & pinA))
                                   : pinA;
         `CSR_OFF_PORT_B_DATA:   rdMux = portReadSourceOption
                                   ? ((dirOutB & state_q.latchB) | (~dirOutB & pinB))
                                   : pinB;
         `CSR_OFF_PORT_C_DATA:   rdMux = {6'h00, portReadSourceOption
                                   ? ((dirOutC & state_q.latchC) | (~dirOutC & pinC))
                                   : pinC};
         `CSR_OFF_POWER:   rdMux = state_q.power;
         `CSR_OFF_WAKEUP:  rdMux = state_q.wakeup;
         `CSR_OFF_PCBUF:   rdMux = {5'h00, state_q.pcHigh};
         default:          rdMux = isSfr ? `CSR_RST_ZERO8 : gprRdata;
      endcase
   end
   assign rdata = rdMux;

   // Next-state: writes land at the end of the cycle, seen next instruction
   always_comb begin
      logic [10:0] pcNext;
      pcNext            = state_q.pc;
      state_d           = state_q;
      state_d.extPrev   = externalTimerClockPin;
      state_d.loscPrev  = lowOscClk;
      state_d.pushValid = 1'b0;

      if (tick) begin
         state_d.timer0 = state_q.timer0 + 8'h01;
      end

      // Counter advance or branch load
      if (instDone) begin
         pcNext = state_q.pc + 11'h001;
         unique case (branch)
            csr_pkg::CSR_BR_NONE: ;
            csr_pkg::CSR_BR_SJMP: begin
               pcNext = {state_q.pcHigh[2:1], branchTarget[8:0]};
            end
            csr_pkg::CSR_BR_SCALL: begin
               pcNext            = {state_q.pcHigh, branchTarget[7:0]};
               state_d.stackPush = state_q.pc + 11'h001;
               state_d.pushValid = 1'b1;
            end
            csr_pkg::CSR_BR_LJMP: begin
               pcNext = branchTarget;
            end
            csr_pkg::CSR_BR_LONG_CALL: begin
               pcNext            = branchTarget;
               state_d.stackPush = state_q.pc + 11'h001;
               state_d.pushValid = 1'b1;
            end
            default: ;
         endcase
      end
      state_d.pc = pcNext;

      // Arithmetic flags; a direct status write below overrides them
      if (alu.upd) begin
         state_d.status[`CSR_ST_CARRY] = alu.carry;
         state_d.status[`CSR_ST_HALF]  = alu.half;
         state_d.status[`CSR_ST_ZERO]  = (alu.result == 8'h00);
      end

      // Register writes, both direct and through the pointer
      if (acc.wr && isSfr) begin
         unique case (effAddr)
            `CSR_OFF_TIMER0:  state_d.timer0  = acc.wdata;
            `CSR_OFF_PCLOW: begin
               // Writing the low byte jumps, upper bits from the buffer
               state_d.pc = {state_q.pcHigh, acc.wdata};
            end
            `CSR_OFF_STATUS:  state_d.status  = acc.wdata;
            `CSR_OFF_POINTER: state_d.pointer = acc.wdata;
            `CSR_OFF_PORT_A_DATA:   state_d.latchA  = acc.wdata;
            `CSR_OFF_PORT_B_DATA:   state_d.latchB  = acc.wdata;
            `CSR_OFF_PORT_C_DATA:   state_d.latchC  = acc.wdata[1:0];
            `CSR_OFF_POWER:   state_d.power   = acc.wdata;
            `CSR_OFF_WAKEUP:  state_d.wakeup  = acc.wdata;
            `CSR_OFF_PCBUF:   state_d.pcHigh  = acc.wdata[2:0];
            default: ;
         endcase
      end

      // Power events win over a software write to the same bits
      if (clrWdtExec) begin
         state_d.status[`CSR_ST_PD_N] = 1'b1;
         state_d.status[`CSR_ST_TO_N] = 1'b1;
      end
      if (sleepExec) begin
         state_d.status[`CSR_ST_PD_N] = 1'b0;
         state_d.status[`CSR_ST_TO_N] = 1'b1;
      end
      if (wdtTimeout) begin
         state_d.status[`CSR_ST_TO_N] = 1'b0;
      end
   end

   // Single state register; power-up values on reset
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q           <= '0;
         state_q.pc        <= {3'h0, `CSR_RST_PCLOW};
         state_q.status    <= `CSR_RST_STATUS;
         state_q.power     <= `CSR_RST_POWER;
         state_q.wakeup    <= `CSR_RST_WAKEUP;
      end else begin
         state_q <= state_d;
      end
   end

   // Outputs straight from the state register
   assign pcOut                  = state_q.pc;
   assign stackPushValid         = state_q.pushValid;
   assign stackPushAddr          = state_q.stackPush;
   assign latchA                 = state_q.latchA;
   assign latchB                 = state_q.latchB;
   assign latchC                 = state_q.latchC;
   assign watchdogEnable         = state_q.power[`CSR_PW_WDT];
   assign lowVoltageResetEnable  = state_q.power[`CSR_PW_LVR];
   assign lowVoltageDetectEnable = state_q.power[`CSR_PW_LVD];
   assign pa5PullupDisable       = state_q.power[`CSR_PW_PA5PU];
   assign pinWakeupEnable        = state_q.wakeup;
   assign bankSelect             = state_q.status[7:6];

endmodule

/* tb/csr_asserts.sv */
// Port-level concurrent checks for the core register bank
module csr_asserts (
   // Clock and reset
   input wire logic                 core_clk,
   input wire logic                 sys_rst,
   // Core access and branch inputs
   input wire csr_pkg::csr_acc_t    acc,
   input wire logic                 instDone,
   input wire csr_pkg::csr_branch_t branch,
   input wire logic [10:0]          branchTarget,
   // Observed outputs
   input wire logic [7:0]           rdata,
   input wire logic [10:0]          pcOut,
   input wire logic                 stackPushValid,
   input wire logic [10:0]          stackPushAddr,
   input wire logic [7:0]           latchA,
   input wire logic                 watchdogEnable,
   input wire logic                 lowVoltageResetEnable,
   input wire logic                 lowVoltageDetectEnable,
   input wire logic                 pa5PullupDisable,
   input wire logic [7:0]           pinWakeupEnable,
   input wire logic [1:0]           bankSelect
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // Direct writes land in the next cycle; indirect ones are left to the bench
   a_wdt_write: assert property (acc.wr && acc.addr == 7'h08 |=>
      watchdogEnable == $past(acc.wdata[7])) else $error("watchdog enable bit wrong");
   a_lv_write: assert property (acc.wr && acc.addr == 7'h08 |=>
      lowVoltageResetEnable == $past(acc.wdata[3]) &&
      lowVoltageDetectEnable == $past(acc.wdata[5])) else $error("low voltage enables wrong");
   a_pullup_write: assert property (acc.wr && acc.addr == 7'h08 |=>
      pa5PullupDisable == $past(acc.wdata[4])) else $error("pull-up control wrong");
   a_wake_write: assert property (acc.wr && acc.addr == 7'h09 |=>
      pinWakeupEnable == $past(acc.wdata)) else $error("wake-up enables wrong");
   a_wake_read: assert property (acc.addr == 7'h09 |-> rdata == pinWakeupEnable)
      else $error("wake-up readback differs");
   a_bank_write: assert property (acc.wr && acc.addr == 7'h03 |=>
      bankSelect == $past(acc.wdata[7:6])) else $error("bank select wrong");
   a_latch_write: assert property (acc.wr && acc.addr == 7'h05 |=>
      latchA == $past(acc.wdata)) else $error("port A latch wrong");
   a_pc_advance: assert property (instDone && branch == csr_pkg::CSR_BR_NONE && !acc.wr
      |=> pcOut == $past(pcOut) + 11'h001) else $error("counter did not advance");
   a_long_load: assert property (instDone && !acc.wr && (branch == csr_pkg::CSR_BR_LJMP ||
      branch == csr_pkg::CSR_BR_LONG_CALL) |=> pcOut == $past(branchTarget))
      else $error("long target not loaded");
   a_call_push: assert property (instDone && !acc.wr && branch == csr_pkg::CSR_BR_LONG_CALL
      |=> stackPushValid && stackPushAddr == $past(pcOut) + 11'h001)
      else $error("call push wrong");
   a_push_cause: assert property (!instDone |=> !stackPushValid)
      else $error("push without call");
endmodule

bind csr_core_special_register_bank csr_asserts u_chk (
   .core_clk(core_clk), .sys_rst(sys_rst), .acc(acc), .instDone(instDone), .branch(branch),
   .branchTarget(branchTarget), .rdata(rdata), .pcOut(pcOut),
   .stackPushValid(stackPushValid), .stackPushAddr(stackPushAddr), .latchA(latchA),
   .watchdogEnable(watchdogEnable), .lowVoltageResetEnable(lowVoltageResetEnable),
   .lowVoltageDetectEnable(lowVoltageDetectEnable), .pa5PullupDisable(pa5PullupDisable),
   .pinWakeupEnable(pinWakeupEnable), .bankSelect(bankSelect));

/* tb/tb_csr_core_special_register_bank.sv */
// Self-checking bench for the core register bank
module tb_csr_core_special_register_bank;
   timeunit 1ns;
   timeprecision 100ps;
   logic                 core_clk = 1'b0;
   logic                 sys_rst = 1'b1;
   csr_pkg::csr_acc_t    acc = '0;
   csr_pkg::csr_alu_t    alu = '0;
   csr_pkg::csr_branch_t branch = csr_pkg::CSR_BR_NONE;
   logic [10:0]          branchTarget = '0;
   logic                 instDone = 1'b0;
   logic [2:0]           evt = '0;
   logic                 modeBit = 1'b0;
   logic                 lowSel = 1'b0;
   logic                 lowClk = 1'b0;
   logic                 extPin = 1'b0;
   logic [7:0]           pinA = '0;
   logic [7:0]           dirOutA = '0;
   logic [1:0]           pinC = '0;
   logic [1:0]           dirOutC = '0;
   logic                 opt = 1'b0;
   logic [7:0]           rdata, latchA, latchB, gprWdata, pinWakeupEnable;
   logic [10:0]          pcOut, stackPushAddr;
   logic [8:0]           gprAddr;
   logic [1:0]           latchC, bankSelect;
   logic                 gprRd, gprWr, stackPushValid, watchdogEnable, lowVoltageResetEnable;
   logic                 lowVoltageDetectEnable, pa5PullupDisable;
   int                   miscompares = 0;
   int                   nCompared = 0;
   int                   cycleCount = 0;

   csr_core_special_register_bank u_dut (
      .core_clk(core_clk), .sys_rst(sys_rst), .acc(acc), .rdata(rdata), .gprRd(gprRd),
      .gprWr(gprWr), .gprAddr(gprAddr), .gprWdata(gprWdata), .gprRdata(8'h77),
      .instDone(instDone), .branch(branch), .branchTarget(branchTarget), .pcOut(pcOut),
      .stackPushValid(stackPushValid), .stackPushAddr(stackPushAddr), .alu(alu),
      .sleepExec(evt[2]), .clrWdtExec(evt[1]), .wdtTimeout(evt[0]),
      .timer0ModeBit(modeBit), .cfgTimer0LowOsc(lowSel), .externalTimerClockPin(extPin),
      .lowOscClk(lowClk), .pinA(pinA), .pinB(8'h00), .pinC(pinC), .dirOutA(dirOutA),
      .dirOutB(8'h00), .dirOutC(dirOutC), .portReadSourceOption(opt), .latchA(latchA),
      .latchB(latchB), .latchC(latchC), .watchdogEnable(watchdogEnable),
      .lowVoltageResetEnable(lowVoltageResetEnable),
      .lowVoltageDetectEnable(lowVoltageDetectEnable), .pa5PullupDisable(pa5PullupDisable),
      .pinWakeupEnable(pinWakeupEnable), .bankSelect(bankSelect));

   // Clock, and a ceiling well above the hundred or so cycles the run needs
   initial forever #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycleCount++;
      if (cycleCount == 2000) begin
         miscompares++;
         end_of_test();
      end
   end

   // Wide enough for the longest packed compare, so no bit is dropped
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         miscompares++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Write held for exactly one sampling edge, then checked just after it
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge core_clk);
      acc <= '{1'b0, 1'b1, a, d};
      @(posedge core_clk);
      acc.wr <= 1'b0;
      #1;
   endtask

   // Read data is combinational, so judge it 2 ns after the edge
   task automatic rdc(input logic [6:0] a, input logic [7:0] e);
      @(posedge core_clk);
      acc <= '{1'b1, 1'b0, a, 8'h00};
      #2;
      chk(rdata, e);
   endtask

   task automatic brn(input csr_pkg::csr_branch_t b, input logic [10:0] t);
      @(posedge core_clk);
      instDone <= 1'b1;
      branch <= b;
      branchTarget <= t;
      @(posedge core_clk);
      instDone <= 1'b0;
      branch <= csr_pkg::CSR_BR_NONE;
      #1;
   endtask

   // One-cycle sleep / clear-watchdog / timeout pulse, or ALU flag update
   task automatic ev(input logic [2:0] m, input csr_pkg::csr_alu_t f);
      @(posedge core_clk);
      evt <= m;
      alu <= f;
      @(posedge core_clk);
      evt <= 3'b000;
      alu <= '0;
   endtask

   task automatic t_reset;
      chk(watchdogEnable, 1'b1);
      chk({lowVoltageResetEnable, lowVoltageDetectEnable, pa5PullupDisable}, 3'b101);
      chk({pinWakeupEnable, bankSelect}, 10'h3fc);
      chk(pcOut, 11'h000);
      rdc(7'h03, 8'h18);
      rdc(7'h08, 8'h98);
   endtask

   task automatic t_branch;
      wr(7'h0a, 8'h05);
      brn(csr_pkg::CSR_BR_SJMP, 11'h134);
      chk(pcOut, 11'h534);
      brn(csr_pkg::CSR_BR_SCALL, 11'h034);
      chk({stackPushValid, pcOut, stackPushAddr}, {1'b1, 11'h534, 11'h535});
      brn(csr_pkg::CSR_BR_LJMP, 11'h7ff);
      chk({stackPushValid, pcOut}, {1'b0, 11'h7ff});
      brn(csr_pkg::CSR_BR_NONE, 11'h155);
      chk(pcOut, 11'h000);
      brn(csr_pkg::CSR_BR_LONG_CALL, 11'h2c3);
      chk({stackPushValid, pcOut, stackPushAddr}, {1'b1, 11'h2c3, 11'h001});
      wr(7'h02, 8'h40);
      chk(pcOut, 11'h540);
      rdc(7'h02, 8'h40);
   endtask

   task automatic t_power;
      wr(7'h08, 8'h28);
      chk({watchdogEnable, lowVoltageDetectEnable, pa5PullupDisable}, 3'b010);
      wr(7'h08, 8'h47);
      chk({lowVoltageResetEnable, lowVoltageDetectEnable}, 2'b00);
      wr(7'h03, 8'hf8);
      chk(bankSelect, 2'h3);
      rdc(7'h03, 8'hf8);
      wr(7'h09, 8'h5a);
      rdc(7'h09, 8'h5a);
      rdc(7'h08, 8'h47);
      wr(7'h03, 8'h18);
      chk(bankSelect, 2'h0);
   endtask

   task automatic t_flags;
      ev(3'b000, '{1'b1, 1'b0, 1'b0, 8'h01});
      rdc(7'h03, 8'h18);
      ev(3'b000, '{1'b1, 1'b1, 1'b1, 8'h00});
      rdc(7'h03, 8'h1f);
      ev(3'b100, '0);
      rdc(7'h03, 8'h17);
      ev(3'b001, '0);
      rdc(7'h03, 8'h07);
      ev(3'b010, '0);
      rdc(7'h03, 8'h1f);
   endtask

   task automatic t_indirect;
      wr(7'h04, 8'h85);
      rdc(7'h04, 8'h85);
      wr(7'h00, 8'ha5);
      chk(latchA, 8'ha5);
      wr(7'h04, 8'h20);
      @(posedge core_clk);
      acc <= '{1'b0, 1'b1, 7'h00, 8'h3c};
      #2;
      chk({gprWr, gprAddr, gprWdata}, {1'b1, 9'h020, 8'h3c});
      @(posedge core_clk);
      acc.wr <= 1'b0;
   endtask

   task automatic t_ports;
      @(posedge core_clk);
      pinA <= 8'h3c;
      dirOutA <= 8'h0f;
      rdc(7'h05, 8'h3c);
      @(posedge core_clk);
      opt <= 1'b1;
      rdc(7'h05, 8'h35);
      wr(7'h06, 8'hc3);
      chk(latchB, 8'hc3);
      wr(7'h07, 8'hff);
      chk(latchC, 2'h3);
      @(posedge core_clk);
      pinC <= 2'b10;
      dirOutC <= 2'b01;
      rdc(7'h07, 8'h03);
      @(posedge core_clk);
      opt <= 1'b0;
      rdc(7'h07, 8'h02);
   endtask

   task automatic t_timer;
      wr(7'h01, 8'h10);
      repeat (3) brn(csr_pkg::CSR_BR_NONE, 11'h000);
      rdc(7'h01, 8'h13);
      @(posedge core_clk);
      modeBit <= 1'b1;
      repeat (2) begin
         @(posedge core_clk);
         extPin <= 1'b1;
         @(posedge core_clk);
         extPin <= 1'b0;
      end
      brn(csr_pkg::CSR_BR_NONE, 11'h000);
      rdc(7'h01, 8'h15);
      // Low oscillator source: one rising edge, instruction pulses ignored
      @(posedge core_clk);
      modeBit <= 1'b0;
      lowSel <= 1'b1;
      @(posedge core_clk);
      lowClk <= 1'b1;
      @(posedge core_clk);
      lowClk <= 1'b0;
      brn(csr_pkg::CSR_BR_NONE, 11'h000);
      rdc(7'h01, 8'h16);
   endtask

   task automatic end_of_test;
      $display("comparisons %0d, mismatches %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Reset for five cycles, then run each scenario in turn
   initial begin
      repeat (5) @(posedge core_clk);
      sys_rst <= 1'b0;
      @(posedge core_clk);
      #1;
      t_reset();
      t_branch();
      t_power();
      t_flags();
      t_indirect();
      t_ports();
      t_timer();
      end_of_test();
   end
endmodule
